// ### cfg_mode_sequencer.sv
/*
  power-up and configuration mode sequencer of a programmable logic device.
  assumes a 100 MHz CLK, synchronous RESET, pins arriving asynchronously,
  and an external source delivering bytes with a valid strobe.
*/
// How it works
// - por delay 100 ms low, 2 ms high
// - user io tri-stated through power-up and loading
// - after load, init resets and enables io
// - load plus init form command mode
// - reconfigure pin returns device to command mode
// - weak pull-ups on outside user mode unless control pin high
// - chain enable in gates, enable out passes on
// - five schemes accepted for configuration
// - parallel schemes take one byte per strobe
// - dual-purpose pins freed after configuration
`timescale 1ns/100ps
module cfg_mode_sequencer
  import cfg_seq_pkg::*;
#(
  parameter int POR_LONG = POR_LONG_CYC,    // long power-on delay cycles
  parameter int POR_SHORT = POR_SHORT_CYC,  // short power-on delay cycles
  parameter int IMAGE_BYTES = 1024          // bytes in one configuration image
) (
  input wire logic CLK,                            // 100 MHz clock
  input wire logic RESET,                          // sync reset, active high
  input wire logic POWER_ON_DELAY_SELECT,          // low 100 ms, high 2 ms
  input wire logic CONFIG_WEAK_PULLUP_CTRL_N,      // low enables pull-ups
  input wire logic CHAIN_CONFIG_ENABLE_IN_N,       // chain enable in, low
  output logic CHAIN_CONFIG_ENABLE_OUT_N,          // chain enable out, low
  input wire logic RECONFIGURE_REQUEST_N,          // low forces reconfiguration
  input wire logic [2:0] SCHEME_SEL,               // configuration scheme
  input wire logic CFG_SERIAL_DATA,                // serial scheme data bit
  input wire logic CFG_BYTE_VALID,                 // byte or bit strobe
  input wire logic [BYTE_W-1:0] CFG_BYTE,          // parallel byte bus
  output logic PARALLEL_READY_BUSY,                // high when a byte can be taken
  output logic CFG_BYTE_READY,                     // fifo can take a byte
  output logic COMMAND_MODE,                       // high in command mode
  output logic USER_MODE,                          // high in user mode
  output logic IO_OUTPUT_ENABLE_N,                 // low lets user io drive
  output logic IO_WEAK_PULLUP_EN,                  // weak pull-ups applied
  output logic DUAL_PURPOSE_USER,                  // config pins in user role
  output logic INIT_RESET,                         // internal register reset
  output logic [BYTE_W-1:0] LOADED_BYTE,           // last byte written to sram
  output logic LOADED_STROBE                       // pulse per byte written
);

  // ----------------------------------------------------------------
  // pin synchronisers: three stages, change counts when 2 and 3 agree
  // ----------------------------------------------------------------
  localparam int NS = 5;
  logic [NS-1:0] pin_raw, s1_ff, s2_ff, s3_ff, flt_ff, nxt_flt;
  assign pin_raw = {POWER_ON_DELAY_SELECT, CONFIG_WEAK_PULLUP_CTRL_N,
                    CHAIN_CONFIG_ENABLE_IN_N, RECONFIGURE_REQUEST_N, CFG_BYTE_VALID};

  always_comb begin
    nxt_flt = flt_ff;
    for (int i = 0; i < NS; i++) begin
      if (s2_ff[i] == s3_ff[i]) nxt_flt[i] = s3_ff[i];
    end
  end

  // idle levels at reset: strobe low, active-low pins high
  always_ff @(posedge CLK) begin
    if (RESET) begin
      s1_ff <= 5'h0e;
      s2_ff <= 5'h0e;
      s3_ff <= 5'h0e;
      flt_ff <= 5'h0e;
    end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      flt_ff <= nxt_flt;
    end
  end

  logic por_sel, pullup_n, ce_in_n, reconf_n, strobe_lvl;
  assign {por_sel, pullup_n, ce_in_n, reconf_n, strobe_lvl} = flt_ff;

  // strobe edge; data sampled at pins is held long by the source
  logic strobe_d_ff, strobe_rise;
  always_ff @(posedge CLK) begin
    if (RESET) strobe_d_ff <= 1'b0;
    else strobe_d_ff <= strobe_lvl;
  end
  assign strobe_rise = strobe_lvl && !strobe_d_ff;

  // ----------------------------------------------------------------
  // serial assembly and fifo input
  // ----------------------------------------------------------------
  scheme_t scheme;
  logic parallel_scheme, serial_scheme, accept;
  logic [BYTE_W-1:0] shift_ff, nxt_shift;
  logic [2:0] bitc_ff, nxt_bitc;
  logic byte_v_ff, nxt_byte_v;
  logic [BYTE_W-1:0] byte_d_ff, nxt_byte_d;

  assign scheme = scheme_t'(SCHEME_SEL);
  assign parallel_scheme = (scheme == SCHEME_PARALLEL_ASYNC) ||
                           (scheme == SCHEME_FAST_PARALLEL);
  // memory and boundary-scan sources stream serially as well
  assign serial_scheme = (scheme == SCHEME_CFG_MEMORY) ||
                         (scheme == SCHEME_PASSIVE_SERIAL) ||
                         (scheme == SCHEME_BOUNDARY_SCAN);

  byte_stream_if #(.W(BYTE_W)) fin();
  byte_stream_if #(.W(BYTE_W)) fout();

  seq_state_t st_ff, nxt_st;
  logic flush;

  // ----------------------------------------------------------------
  // byte capture, one byte per strobe in parallel schemes
  // ----------------------------------------------------------------
  always_comb begin
    nxt_shift = shift_ff;
    nxt_bitc = bitc_ff;
    nxt_byte_v = byte_v_ff && !fin.ready;
    nxt_byte_d = byte_d_ff;
    if (flush) begin
      nxt_bitc = '0;
      nxt_byte_v = 1'b0;
    end else if (accept && strobe_rise && !nxt_byte_v) begin
      if (parallel_scheme) begin
        nxt_byte_d = CFG_BYTE;
        nxt_byte_v = 1'b1;
      end else if (serial_scheme) begin
        nxt_shift = {CFG_SERIAL_DATA, shift_ff[BYTE_W-1:1]};  // lsb first
        nxt_bitc = bitc_ff + 3'h1;
        if (bitc_ff == 3'h7) begin
          nxt_byte_d = {CFG_SERIAL_DATA, shift_ff[BYTE_W-1:1]};
          nxt_byte_v = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      shift_ff <= 8'h00;
      bitc_ff <= 3'h0;
      byte_v_ff <= 1'b0;
      byte_d_ff <= 8'h00;
    end else begin
      shift_ff <= nxt_shift;
      bitc_ff <= nxt_bitc;
      byte_v_ff <= nxt_byte_v;
      byte_d_ff <= nxt_byte_d;
    end
  end

  assign fin.valid = byte_v_ff;
  assign fin.data = byte_d_ff;

  cfg_byte_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .rst(RESET),
    .flush(flush),
    .wr(fin),
    .rd(fout)
  );

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  logic [POR_CNT_W-1:0] por_ff, nxt_por;
  logic [LOAD_CNT_W-1:0] load_ff, nxt_load;
  logic [INIT_CNT_W-1:0] init_ff, nxt_init;
  logic [POR_CNT_W-1:0] por_target;
  logic [BYTE_W-1:0] out_d_ff, nxt_out_d;
  logic out_s_ff, nxt_out_s;

  // pin is sampled continuously during power-on; it is a static strap
  assign por_target = por_sel ? POR_CNT_W'(POR_SHORT - 1)
                              : POR_CNT_W'(POR_LONG - 1);

  always_comb begin
    nxt_st = st_ff;
    nxt_por = por_ff;
    nxt_load = load_ff;
    nxt_init = init_ff;
    nxt_out_d = out_d_ff;
    nxt_out_s = 1'b0;
    fout.ready = 1'b0;
    case (st_ff)
      ST_POR: begin
        nxt_por = por_ff + POR_CNT_W'(1);
        if (por_ff >= por_target) nxt_st = ST_WAIT_CE;
      end
      ST_WAIT_CE: begin
        nxt_load = '0;
        if (!ce_in_n) nxt_st = ST_LOAD;
      end
      ST_LOAD: begin
        fout.ready = 1'b1;
        if (fout.valid) begin
          nxt_out_d = fout.data;
          nxt_out_s = 1'b1;
          nxt_load = load_ff + LOAD_CNT_W'(1);
          if (load_ff == LOAD_CNT_W'(IMAGE_BYTES - 1)) begin
            nxt_st = ST_INIT;
            nxt_init = '0;
          end
        end
        if (ce_in_n) nxt_st = ST_WAIT_CE;  // chain enable withdrawn
      end
      ST_INIT: begin
        nxt_init = init_ff + INIT_CNT_W'(1);
        if (init_ff == INIT_CNT_W'(INIT_CYC - 1)) nxt_st = ST_USER;
      end
      ST_USER: ;
      ST_RECONF: begin
        if (reconf_n) nxt_st = ST_WAIT_CE;
      end
      default: nxt_st = ST_POR;
    endcase
    // reconfigure pin overrides any state after power-on
    if (!reconf_n && st_ff != ST_POR) nxt_st = ST_RECONF;
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_ff <= ST_POR;
      por_ff <= '0;
      load_ff <= '0;
      init_ff <= '0;
      out_d_ff <= 8'h00;
      out_s_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      por_ff <= nxt_por;
      load_ff <= nxt_load;
      init_ff <= nxt_init;
      out_d_ff <= nxt_out_d;
      out_s_ff <= nxt_out_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic in_user, in_cmd, done_ff;
  assign in_user = (st_ff == ST_USER);
  assign in_cmd = !in_user && (st_ff != ST_POR);
  assign accept = (st_ff == ST_LOAD);
  assign flush = (st_ff != ST_LOAD);   // stale bytes never reach a new image

  // enable out goes low once this device is fully loaded
  always_ff @(posedge CLK) begin
    if (RESET) done_ff <= 1'b0;
    else done_ff <= (st_ff == ST_INIT) || in_user;
  end

  assign CHAIN_CONFIG_ENABLE_OUT_N = !done_ff;
  assign PARALLEL_READY_BUSY = accept && !byte_v_ff && parallel_scheme;
  assign CFG_BYTE_READY = fin.ready;
  assign COMMAND_MODE = in_cmd;
  assign USER_MODE = in_user;
  // io stays released until init has run; init drives it on
  assign IO_OUTPUT_ENABLE_N = !in_user;
  assign IO_WEAK_PULLUP_EN = !in_user && !pullup_n;
  assign DUAL_PURPOSE_USER = in_user;
  assign INIT_RESET = (st_ff == ST_INIT);
  assign LOADED_BYTE = out_d_ff;
  assign LOADED_STROBE = out_s_ff;
endmodule // cfg_mode_sequencer

// ### cfg_seq_pkg.sv
/*
  constants shared by the configuration mode sequencer and its byte fifo.
  assumes a single 100 MHz clock and a synchronous active-high reset.
*/
package cfg_seq_pkg;

  // ----------------------------------------------------------------
  // clock and power-on timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int POR_LONG_MS = 100;
  localparam int POR_SHORT_MS = 2;
  localparam int POR_LONG_CYC = POR_LONG_MS * 1000000 / CLK_PERIOD_NS;
  localparam int POR_SHORT_CYC = POR_SHORT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int POR_CNT_W = 24;

  // ----------------------------------------------------------------
  // data path and init timing
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int INIT_CYC = 16;
  localparam int INIT_CNT_W = 5;
  localparam int LOAD_CNT_W = 32;

  // ----------------------------------------------------------------
  // configuration schemes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SCHEME_CFG_MEMORY = 3'b000,
    SCHEME_PASSIVE_SERIAL = 3'b001,
    SCHEME_PARALLEL_ASYNC = 3'b010,
    SCHEME_FAST_PARALLEL = 3'b011,
    SCHEME_BOUNDARY_SCAN = 3'b100
  } scheme_t;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POR = 3'b000,
    ST_WAIT_CE = 3'b001,
    ST_LOAD = 3'b010,
    ST_INIT = 3'b011,
    ST_USER = 3'b100,
    ST_RECONF = 3'b101
  } seq_state_t;

endpackage

// ### byte_stream_if.sv
/*
  valid/ready byte stream carrier between the sequencer and its fifo.
  assumes both ends share one clock.
*/
`timescale 1ns/100ps
interface byte_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### cfg_byte_fifo.sv
/*
  small synchronous fifo holding configuration bytes.
  assumes one clock, synchronous active-high reset, flush by the owner.
*/
`timescale 1ns/100ps
module cfg_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,              // system clock
  input wire logic rst,              // sync reset, active high
  input wire logic flush,            // drop all stored words
  byte_stream_if.snk wr,             // filling side
  byte_stream_if.src rd              // draining side
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wptr_ff, nxt_wptr, rptr_ff, nxt_rptr;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic push, pop;

  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  assign wr.ready = (cnt_ff != (AW+1)'(DEPTH)) && !flush;
  assign rd.valid = (cnt_ff != '0);
  assign rd.data = mem_ff[rptr_ff];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  // pointer and count next values
  always_comb begin
    nxt_wptr = wptr_ff;
    nxt_rptr = rptr_ff;
    nxt_cnt = cnt_ff;
    if (flush) begin
      nxt_wptr = '0;
      nxt_rptr = '0;
      nxt_cnt = '0;
    end else begin
      if (push) nxt_wptr = (wptr_ff == AW'(DEPTH - 1)) ? '0 : wptr_ff + AW'(1);
      if (pop) nxt_rptr = (rptr_ff == AW'(DEPTH - 1)) ? '0 : rptr_ff + AW'(1);
      nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage is not reset; only pointers and count carry control meaning
  always_ff @(posedge clk) begin
    if (rst) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wptr_ff <= nxt_wptr;
      rptr_ff <= nxt_rptr;
      cnt_ff <= nxt_cnt;
    end
    if (push) mem_ff[wptr_ff] <= wr.data;
  end
endmodule // cfg_byte_fifo

// ### cfg_mode_sequencer_sva.sv
/*
  assertions on the sequencer's mode, io and load outputs.
  assumes a bind to cfg_mode_sequencer and its single clock.
*/
`timescale 1ns/100ps
module cfg_mode_sequencer_sva (
  input wire logic CLK,                        // clock
  input wire logic RESET,                      // sync reset
  input wire logic CONFIG_WEAK_PULLUP_CTRL_N,  // pull-up control pin
  input wire logic RECONFIGURE_REQUEST_N,      // reconfigure pin
  input wire logic CHAIN_CONFIG_ENABLE_OUT_N,  // chain enable out
  input wire logic COMMAND_MODE,               // command mode flag
  input wire logic USER_MODE,                  // user mode flag
  input wire logic IO_OUTPUT_ENABLE_N,         // io drive enable
  input wire logic IO_WEAK_PULLUP_EN,          // pull-ups on
  input wire logic DUAL_PURPOSE_USER,          // pins in user role
  input wire logic INIT_RESET,                 // init phase reset
  input wire logic LOADED_STROBE               // byte written pulse
);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // init phase is sixteen cycles at least
  sequence init_run;
    INIT_RESET[*8] ##1 INIT_RESET[*8];
  endsequence
  // pin held low long enough to pass the synchroniser
  sequence reconf_held;
    !RECONFIGURE_REQUEST_N[*6];
  endsequence

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_io_tristate: assert property (!USER_MODE |-> IO_OUTPUT_ENABLE_N)
    else $error("io driven outside user mode");
  a_mode_exclusive: assert property (!(COMMAND_MODE && USER_MODE))
    else $error("both modes at once");
  a_pullup_user: assert property (USER_MODE |-> !IO_WEAK_PULLUP_EN)
    else $error("pull-ups on in user mode");
  // pin sampled through a synchroniser, so only steady levels are judged
  a_pullup_config: assert property (COMMAND_MODE
    && $past(CONFIG_WEAK_PULLUP_CTRL_N, 5) == CONFIG_WEAK_PULLUP_CTRL_N
    && $past(CONFIG_WEAK_PULLUP_CTRL_N, 2) == CONFIG_WEAK_PULLUP_CTRL_N
    |-> IO_WEAK_PULLUP_EN == !CONFIG_WEAK_PULLUP_CTRL_N)
    else $error("pull-up state wrong in command mode");
  a_dual_user: assert property (DUAL_PURPOSE_USER == USER_MODE)
    else $error("dual-purpose role wrong");
  a_init_length: assert property ($rose(INIT_RESET) |-> init_run)
    else $error("init phase too short");
  a_init_user: assert property ($fell(INIT_RESET) |-> ##[0:2] USER_MODE)
    else $error("no user mode after init");
  a_user_entry: assert property ($rose(USER_MODE)
    |-> $past(COMMAND_MODE) && !CHAIN_CONFIG_ENABLE_OUT_N)
    else $error("user mode entered wrongly");
  a_reconf_cmd: assert property (USER_MODE ##1 reconf_held
    |-> COMMAND_MODE && IO_OUTPUT_ENABLE_N)
    else $error("reconfigure ignored");
  a_idle_load: assert property (!COMMAND_MODE |-> !LOADED_STROBE)
    else $error("byte loaded outside command mode");
  a_strobe_pulse: assert property (LOADED_STROBE |=> !LOADED_STROBE)
    else $error("load strobe longer than one cycle");
endmodule // cfg_mode_sequencer_sva

bind cfg_mode_sequencer cfg_mode_sequencer_sva chk_i (.CLK, .RESET,
  .CONFIG_WEAK_PULLUP_CTRL_N, .RECONFIGURE_REQUEST_N, .CHAIN_CONFIG_ENABLE_OUT_N,
  .COMMAND_MODE, .USER_MODE, .IO_OUTPUT_ENABLE_N, .IO_WEAK_PULLUP_EN,
  .DUAL_PURPOSE_USER, .INIT_RESET, .LOADED_STROBE);

// ### cfg_source_model.sv
/*
  configuration data source: serial bits or parallel bytes with a strobe.
  assumes the bench calls its tasks and shares the sequencer clock.
*/
`timescale 1ns/100ps
module cfg_source_model
  import cfg_seq_pkg::*;
(
  input wire logic clk,              // system clock
  input wire logic [2:0] scheme,     // selected scheme
  input wire logic ready_busy,       // device can take a byte
  output logic valid,                // data strobe
  output logic [BYTE_W-1:0] data,    // parallel byte
  output logic sdata                 // serial bit
);
  initial begin
    valid = 1'b0;
    data = 8'h00;
    sdata = 1'b0;
  end
  // strobe high and low six cycles each, above the synchroniser minimum
  task automatic pulse();
    @(posedge clk) valid <= 1'b1;
    repeat (6) @(posedge clk);
    valid <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // released lines show the inverse, never a stale copy
  task automatic send_byte(input logic [BYTE_W-1:0] b);
    int n;
    n = 0;
    if (scheme == SCHEME_PARALLEL_ASYNC || scheme == SCHEME_FAST_PARALLEL) begin
      while (ready_busy !== 1'b1 && n < 200) begin
        @(posedge clk);
        n++;
      end
      @(posedge clk) data <= b;
      pulse();
      data <= ~b;
    end else begin
      // scan source sees this device first in its chain, well inside 17
      for (int i = 0; i < BYTE_W; i++) begin
        @(posedge clk) sdata <= b[i];
        pulse();
        sdata <= ~b[i];
      end
    end
  endtask
endmodule // cfg_source_model

// ### test_fpga_config_mode_sequencer.sv
/*
  self-checking bench for the configuration mode sequencer.
  assumes shortened power-on delays and an eight byte image.
*/
`timescale 1ns/100ps
module test_fpga_config_mode_sequencer;
  import cfg_seq_pkg::*;
  localparam int LONG_DLY = 50;
  localparam int SHORT_DLY = 10;
  localparam int NB = 8;
  logic CLK, RESET, SEL, PU_N, CE_IN_N, CE_OUT_N, RECONF_N, SDATA, VALID;
  logic [2:0] SCHEME;
  logic [7:0] BYTE_IN, LBYTE;
  logic RDY, FREADY, CMD, USR, OE_N, PU_EN, DUAL, INIT, LSTB;
  logic [7:0] got[$];
  int fails, n_checks;

  cfg_mode_sequencer #(.POR_LONG(LONG_DLY), .POR_SHORT(SHORT_DLY), .IMAGE_BYTES(NB))
    cfg_mode_sequencer_i (.CLK(CLK), .RESET(RESET), .POWER_ON_DELAY_SELECT(SEL),
    .CONFIG_WEAK_PULLUP_CTRL_N(PU_N), .CHAIN_CONFIG_ENABLE_IN_N(CE_IN_N),
    .CHAIN_CONFIG_ENABLE_OUT_N(CE_OUT_N), .RECONFIGURE_REQUEST_N(RECONF_N),
    .SCHEME_SEL(SCHEME), .CFG_SERIAL_DATA(SDATA), .CFG_BYTE_VALID(VALID),
    .CFG_BYTE(BYTE_IN), .PARALLEL_READY_BUSY(RDY), .CFG_BYTE_READY(FREADY),
    .COMMAND_MODE(CMD), .USER_MODE(USR), .IO_OUTPUT_ENABLE_N(OE_N),
    .IO_WEAK_PULLUP_EN(PU_EN), .DUAL_PURPOSE_USER(DUAL), .INIT_RESET(INIT),
    .LOADED_BYTE(LBYTE), .LOADED_STROBE(LSTB));
  cfg_source_model cfg_source_model_i (.clk(CLK), .scheme(SCHEME), .ready_busy(RDY),
    .valid(VALID), .data(BYTE_IN), .sdata(SDATA));

  // ----------------------------------------------------------------
  // clock, monitor and compare helpers
  // ----------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // every written byte is kept for comparison against the image
  always @(posedge CLK) if (LSTB === 1'b1) got.push_back(LBYTE);
  task automatic check_bit(input logic g, input logic e, input string m);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t byte %h expected %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // power-on delay measured from reset release; the long case strobes early
  task automatic por_test(input logic sel, input int exp);
    int n;
    RESET <= 1'b1;
    SEL <= sel;
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
    got.delete();
    n = 0;
    if (!sel) begin
      cfg_source_model_i.pulse();
      n = 13;
    end
    while (CMD !== 1'b1 && n < 500) begin
      check_bit(OE_N, 1'b1, "io not tristated in power-up");
      @(posedge CLK);
      n++;
    end
    check_bit(n >= exp && n <= exp + 12, 1'b1, "power-on delay wrong");
    check_bit(PU_EN, !PU_N, "pull-up state wrong in config");
    check_bit(got.size() == 0, 1'b1, "byte taken before load");
    check_bit(FREADY, 1'b0, "fifo open before load");
  endtask
  // one image through the given scheme, then user mode outputs
  task automatic load_image(input logic [7:0] base);
    int n;
    repeat (8) @(posedge CLK);
    for (int i = 0; i < NB; i++) cfg_source_model_i.send_byte(base + 8'(i));
    n = 0;
    while (USR !== 1'b1 && n < 2000) begin
      @(posedge CLK);
      n++;
    end
    check_bit(USR, 1'b1, "no user mode");
    check_bit(got.size() == NB, 1'b1, "byte count wrong");
    for (int i = 0; i < NB && i < got.size(); i++) check_byte(got[i], base + 8'(i));
    check_bit(CMD, 1'b0, "command mode in user mode");
    check_bit(OE_N, 1'b0, "io not enabled");
    check_bit(DUAL, 1'b1, "pins not in user role");
    check_bit(RDY, 1'b0, "parallel ready in user mode");
    check_bit(CE_OUT_N, 1'b0, "chain out not passed on");
    got.delete();
  endtask
  // pin pulse drops the device back to command mode with a new scheme
  task automatic reconf(input logic [2:0] s);
    RECONF_N <= 1'b0;
    SCHEME <= s;
    repeat (8) @(posedge CLK);
    check_bit(CMD, 1'b1, "reconfigure ignored");
    check_bit(USR, 1'b0, "still in user mode");
    check_bit(OE_N, 1'b1, "io driven in reconfigure");
    RECONF_N <= 1'b1;
  endtask
  // chain enable held off and pull-ups disabled by the control pin
  task automatic chain_test();
    PU_N <= 1'b1;
    CE_IN_N <= 1'b1;
    por_test(1'b1, SHORT_DLY);
    repeat (40) @(posedge CLK);
    check_bit(PU_EN, 1'b0, "pull-ups not disabled");
    check_bit(CE_OUT_N, 1'b1, "chain out before load");
    check_bit(USR, 1'b0, "user mode without load");
    PU_N <= 1'b0;
    CE_IN_N <= 1'b0;
    repeat (8) @(posedge CLK);
    check_bit(PU_EN, 1'b1, "pull-ups not enabled");
    load_image(8'h5a);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    fails = 0;
    n_checks = 0;
    RESET = 1'b1;
    SEL = 1'b1;
    PU_N = 1'b0;
    CE_IN_N = 1'b0;
    RECONF_N = 1'b1;
    SCHEME = SCHEME_FAST_PARALLEL;
    por_test(1'b1, SHORT_DLY);
    load_image(8'hf8);
    for (int s = 0; s < 5; s++) begin
      reconf(3'(s));
      load_image(8'(8'h10 * s + 8'h01));
    end
    por_test(1'b0, LONG_DLY);
    load_image(8'hc0);
    chain_test();
    give_verdict();
  end
  // whole run needs about five thousand one hundred cycles
  initial begin
    #300000;
    fails++;
    give_verdict();
  end
endmodule // test_fpga_config_mode_sequencer
